// ### hw/scg_fault_check.sv
// Bus fault decision for accesses to the gated units
`timescale 1ns/100ps
module scg_fault_check
    import scg_pkg::*;
(
    input wire logic [NUM_UNITS-1:0] unit_access,
    input wire logic [NUM_UNITS-1:0] unit_clock_enable,
    output logic [NUM_UNITS-1:0] unit_fault,
    output logic any_fault
);

    // ========================================================================
    // An access to an unclocked unit faults instead of completing
    always_comb begin
        unit_fault = unit_access & ~unit_clock_enable;
        any_fault = |unit_fault;
    end

endmodule

// ### hw/scg_gate_select.sv
// Chooses the gating word in force and drives the unit clock enables
`timescale 1ns/100ps
module scg_gate_select
    import scg_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic sleep_active,
    input wire logic deep_sleep_active,
    input wire logic auto_clock_gating_select,
    input wire logic [31:0] run_unit_clock_gating0,
    input wire logic [31:0] sleep_unit_clock_gating0,
    input wire logic [31:0] deep_sleep_unit_clock_gating0,
    output logic [NUM_UNITS-1:0] unit_clock_enable,
    output logic [1:0] converter_sample_rate,
    output scg_mode_type gating_mode,
    output logic sleep_entered
);

    typedef struct packed {
        scg_mode_type mode;
        logic [NUM_UNITS-1:0] en;
        logic [1:0] rate;
        logic entered;
    } scg_sel_state_type;

    scg_sel_state_type r;
    scg_sel_state_type next_r;
    logic [31:0] word;

    // ========================================================================
    // Selection
    always_comb begin
        next_r = r;
        next_r.mode = MODE_RUN;
        word = run_unit_clock_gating0;
        if (auto_clock_gating_select && sleep_active) begin
            next_r.mode = MODE_SLEEP;
            word = sleep_unit_clock_gating0;
        end else if (auto_clock_gating_select && deep_sleep_active) begin
            next_r.mode = MODE_DEEP;
            word = deep_sleep_unit_clock_gating0;
        end
        next_r.en = scg_units(word);
        next_r.rate = word[RATE_MSB:RATE_LSB];
        next_r.entered = (next_r.mode == MODE_SLEEP) &&
                         (r.mode != MODE_SLEEP);
    end

    // ========================================================================
    // State register; reset enables follow the gating reset value
    always_ff @(posedge clock) begin
        if (!nrst) begin
            r.mode <= MODE_RUN;
            r.en <= scg_units(SLEEP_GATING_RESET);
            r.rate <= RATE_125K;
            r.entered <= 1'b0;
        end else begin
            r <= next_r;
        end
    end

    assign unit_clock_enable = r.en;
    assign converter_sample_rate = r.rate;
    assign gating_mode = r.mode;
    assign sleep_entered = r.entered;

endmodule

// ### hw/scg_sleep_gating.sv
// Sleep-mode unit clock gating register block with AHB-Lite slave
//
// Notes on behaviour
// - A set gating bit clocks and enables its unit; clear leaves it off.
// - Access to an unclocked unit is answered with a bus fault.
// - Reset clears every gating bit except hibernation: value 0x40.
// - The sleep gating word governs unit clocks only while in Sleep.
// - Sleep word applies only with auto gating select set, else run word.
// - Bit 20 gates the PWM unit clock, read-write, reset zero.
// - Bit 16 gates converter module 0 clock, read-write, reset zero.
// - Bits 9:8 pick converter rate: 125K, 250K, 500K samples per second.
// - Bit 6 gates the hibernation unit, read-write, resets to one.
// - Bit 3 gates the watchdog unit clock, read-write, reset zero.
// - Reserved bits are read-only zero; software preserves them.
//
// The AHB-Lite slave port was chosen for this implementation.
`timescale 1ns/100ps
module scg_sleep_gating
    import scg_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic sleep_active,
    input wire logic deep_sleep_active,
    input wire logic [31:0] run_unit_clock_gating0,
    input wire logic [31:0] deep_sleep_unit_clock_gating0,
    input wire logic [NUM_UNITS-1:0] unit_access,
    output logic [NUM_UNITS-1:0] unit_clock_enable,
    output logic [1:0] converter_sample_rate,
    output logic [NUM_UNITS-1:0] unit_fault,
    output logic irq
);

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_BUSY,
        ST_ACK
    } scg_bus_state_type;

    typedef struct packed {
        scg_bus_state_type state;
        logic [ADDR_BITS-1:0] addr;
        logic write;
        logic [31:0] rdata;
        logic [31:0] sleep_gating;
        logic auto_select;
        logic [EV_WIDTH-1:0] ev_status;
        logic [EV_WIDTH-1:0] ev_enable;
    } scg_top_state_type;

    scg_top_state_type r;
    scg_top_state_type next_r;

    logic take;
    logic any_fault;
    logic sleep_entered;
    logic [EV_WIDTH-1:0] ev_set;
    logic [EV_WIDTH-1:0] ev_clear;
    scg_mode_type gating_mode;

    // ========================================================================
    // Gating selection and fault decision
    scg_gate_select u_select (
        .clock(clock),
        .nrst(nrst),
        .sleep_active(sleep_active),
        .deep_sleep_active(deep_sleep_active),
        .auto_clock_gating_select(r.auto_select),
        .run_unit_clock_gating0(run_unit_clock_gating0),
        .sleep_unit_clock_gating0(r.sleep_gating),
        .deep_sleep_unit_clock_gating0(deep_sleep_unit_clock_gating0),
        .unit_clock_enable(unit_clock_enable),
        .converter_sample_rate(converter_sample_rate),
        .gating_mode(gating_mode),
        .sleep_entered(sleep_entered)
    );

    scg_fault_check u_fault (
        .unit_access(unit_access),
        .unit_clock_enable(unit_clock_enable),
        .unit_fault(unit_fault),
        .any_fault(any_fault)
    );

    // ========================================================================
    // Read multiplexer
    function automatic logic [31:0] read_word(
        input scg_top_state_type s,
        input logic [NUM_UNITS-1:0] en,
        input logic [1:0] rate,
        input scg_mode_type mode
    );
        logic [31:0] d;
        d = '0;
        unique case (s.addr)
            SLEEP_GATING_OFFSET: begin
                // Reserved bits never hold anything but zero
                d = s.sleep_gating & SLEEP_GATING_WMASK;
            end
            GATING_STATUS_OFFSET: begin
                d[NUM_UNITS-1:0] = en;
                d[STATUS_RATE_LSB+:2] = rate;
                d[STATUS_MODE_LSB+:2] = mode;
            end
            GATING_MODE_OFFSET: begin
                d[AUTO_SELECT_BIT] = s.auto_select;
            end
            EVENT_STATUS_OFFSET: begin
                d[EV_WIDTH-1:0] = s.ev_status;
            end
            EVENT_ENABLE_OFFSET: begin
                d[EV_WIDTH-1:0] = s.ev_enable;
            end
            default: begin
                d = '0;
            end
        endcase
        return d;
    endfunction

    // ========================================================================
    // Bus handshake, register writes and event flags
    always_comb begin
        next_r = r;
        take = hsel && hready && htrans[1] && (r.state != ST_BUSY);
        ev_clear = '0;
        ev_set = '0;
        ev_set[EV_FAULT] = any_fault;
        ev_set[EV_SLEEP] = sleep_entered;

        unique case (r.state)
            ST_IDLE: begin
                next_r.state = ST_IDLE;
            end
            ST_BUSY: begin
                next_r.state = ST_ACK;
                if (r.write) begin
                    next_r.rdata = '0;
                    unique case (r.addr)
                        SLEEP_GATING_OFFSET: begin
                            // Only the gating bits and rate field store
                            next_r.sleep_gating =
                                hwdata & SLEEP_GATING_WMASK;
                        end
                        GATING_MODE_OFFSET: begin
                            next_r.auto_select = hwdata[AUTO_SELECT_BIT];
                        end
                        EVENT_CLEAR_OFFSET: begin
                            ev_clear = hwdata[EV_WIDTH-1:0];
                        end
                        EVENT_ENABLE_OFFSET: begin
                            next_r.ev_enable = hwdata[EV_WIDTH-1:0];
                        end
                        default: begin
                            next_r.rdata = '0;
                        end
                    endcase
                end else begin
                    next_r.rdata = read_word(r, unit_clock_enable,
                                             converter_sample_rate,
                                             gating_mode);
                end
            end
            ST_ACK: begin
                next_r.state = ST_IDLE;
            end
        endcase

        if (take) begin
            next_r.state = ST_BUSY;
            next_r.addr = haddr[ADDR_BITS-1:0];
            next_r.write = hwrite;
        end

        // A new event wins over a clear in the same cycle
        next_r.ev_status = (r.ev_status & ~ev_clear) | ev_set;
    end

    // ========================================================================
    // State register
    always_ff @(posedge clock) begin
        if (!nrst) begin
            r.state <= ST_IDLE;
            r.addr <= '0;
            r.write <= 1'b0;
            r.rdata <= '0;
            r.sleep_gating <= SLEEP_GATING_RESET;
            r.auto_select <= 1'b0;
            r.ev_status <= '0;
            r.ev_enable <= '0;
        end else begin
            r <= next_r;
        end
    end

    // ========================================================================
    // Outputs
    assign hrdata = r.rdata;
    assign hreadyout = (r.state != ST_BUSY);
    assign hresp = 1'b0;
    assign irq = |(r.ev_status & r.ev_enable);

    // Transfer size is ignored: the bus carries whole words only

endmodule

// ### inc/scg_pkg.sv
// Package: register map, field layout and shared helpers of the sleep gating block
package scg_pkg;

    // ========================================================================
    // Register map (byte addresses, low address bits only)
    localparam int ADDR_BITS = 12;
    localparam logic [11:0] SLEEP_GATING_OFFSET = 12'h110;
    localparam logic [11:0] GATING_STATUS_OFFSET = 12'h1e0;
    localparam logic [11:0] GATING_MODE_OFFSET = 12'h1e4;
    localparam logic [11:0] EVENT_STATUS_OFFSET = 12'h1e8;
    localparam logic [11:0] EVENT_CLEAR_OFFSET = 12'h1ec;
    localparam logic [11:0] EVENT_ENABLE_OFFSET = 12'h1f0;

    // ========================================================================
    // Gating register layout
    localparam int PWM_BIT = 20;
    localparam int ADC_BIT = 16;
    localparam int RATE_MSB = 9;
    localparam int RATE_LSB = 8;
    localparam int HIB_BIT = 6;
    localparam int WDT_BIT = 3;
    localparam logic [31:0] SLEEP_GATING_RESET = 32'h0000_0040;
    localparam logic [31:0] SLEEP_GATING_WMASK = 32'h0011_0348;

    // Converter sample rate codes
    localparam logic [1:0] RATE_125K = 2'h0;
    localparam logic [1:0] RATE_250K = 2'h1;
    localparam logic [1:0] RATE_500K = 2'h2;

    // Unit index in the unit vectors
    localparam int UNIT_PWM = 0;
    localparam int UNIT_ADC = 1;
    localparam int UNIT_HIB = 2;
    localparam int UNIT_WDT = 3;
    localparam int NUM_UNITS = 4;

    // ========================================================================
    // Mode control register, status register fields and event registers
    localparam int AUTO_SELECT_BIT = 0;
    localparam int EV_FAULT = 0;
    localparam int EV_SLEEP = 1;
    localparam int EV_WIDTH = 2;
    localparam int STATUS_RATE_LSB = 8;
    localparam int STATUS_MODE_LSB = 16;

    typedef enum logic [1:0] {
        MODE_RUN,
        MODE_SLEEP,
        MODE_DEEP
    } scg_mode_type;

    // Pulls the unit enables out of a gating word
    function automatic logic [NUM_UNITS-1:0] scg_units(
        input logic [31:0] w
    );
        logic [NUM_UNITS-1:0] u;
        u = '0;
        u[UNIT_PWM] = w[PWM_BIT];
        u[UNIT_ADC] = w[ADC_BIT];
        u[UNIT_HIB] = w[HIB_BIT];
        u[UNIT_WDT] = w[WDT_BIT];
        return u;
    endfunction

endpackage

// ### tb/scg_monitor.sv
// Checker of bus timing, reset values and run word selection outside sleep
`timescale 1ns/100ps
module scg_monitor
    import scg_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic sleep_active,
    input wire logic deep_sleep_active,
    input wire logic [31:0] run_unit_clock_gating0,
    input wire logic [NUM_UNITS-1:0] unit_access,
    input wire logic [NUM_UNITS-1:0] unit_clock_enable,
    input wire logic [1:0] converter_sample_rate,
    input wire logic [NUM_UNITS-1:0] unit_fault,
    input wire logic irq
);
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    logic run_seen;
    logic [31:0] run_word;
    // ====
    // Run word of the previous cycle, for the selection checks
    always_ff @(posedge clock) begin
        run_seen <= nrst && !sleep_active && !deep_sleep_active;
        run_word <= run_unit_clock_gating0;
    end
    chk_fault_gate: assert property (
        unit_fault == (unit_access & ~unit_clock_enable))
        else $error("unit fault does not follow gating");
    chk_resp_okay: assert property (hresp == 1'b0)
        else $error("bus response not okay");
    chk_one_wait: assert property (
        hsel && hready && htrans[1] && hreadyout |=> !hreadyout ##1 hreadyout)
        else $error("data phase not one wait cycle");
    chk_rdata_hold: assert property (
        $past(nrst) && $changed(hrdata) |-> $past(hreadyout) == 1'b0)
        else $error("read data changed outside a data phase");
    chk_reset_units: assert property (disable iff (1'b0)
        !nrst |=> unit_clock_enable == 4'b0100)
        else $error("unit enables wrong after reset");
    chk_reset_rate: assert property (disable iff (1'b0)
        !nrst |=> converter_sample_rate == 2'h0 && !irq)
        else $error("rate or interrupt wrong after reset");
    chk_run_units: assert property (run_seen |->
        unit_clock_enable == {run_word[3], run_word[6], run_word[16],
        run_word[20]})
        else $error("run word not in force outside sleep");
    chk_run_rate: assert property (run_seen |->
        converter_sample_rate == run_word[9:8])
        else $error("run rate not in force outside sleep");
    cover property (unit_fault != '0);
    cover property (sleep_active && unit_clock_enable == 4'b1011);
    cover property (irq);
endmodule
bind scg_sleep_gating scg_monitor mon (.clock(clock), .nrst(nrst),
    .hsel(hsel), .htrans(htrans), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .sleep_active(sleep_active),
    .deep_sleep_active(deep_sleep_active),
    .run_unit_clock_gating0(run_unit_clock_gating0),
    .unit_access(unit_access), .unit_clock_enable(unit_clock_enable),
    .converter_sample_rate(converter_sample_rate),
    .unit_fault(unit_fault), .irq(irq));

// ### tb/scg_unit_model.sv
// Model of the gated units: issues accesses and records the outcome
`timescale 1ns/100ps
module scg_unit_model
    import scg_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic go,
    input wire logic [NUM_UNITS-1:0] pick,
    input wire logic [NUM_UNITS-1:0] unit_clock_enable,
    input wire logic [NUM_UNITS-1:0] unit_fault,
    output logic [NUM_UNITS-1:0] unit_access,
    output logic [NUM_UNITS-1:0] served,
    output logic [NUM_UNITS-1:0] refused
);
    always_ff @(posedge clock) begin
        if (!nrst) begin
            unit_access <= '0;
            served <= '0;
            refused <= '0;
        end else begin
            unit_access <= go ? pick : '0;
            if (unit_access != '0) begin
                // Only a clocked unit carries out the access
                served <= unit_access & unit_clock_enable;
                refused <= unit_access & unit_fault;
            end
        end
    end
endmodule

// ### tb/testbench.sv
// Testbench of the sleep gating register block
`timescale 1ns/100ps
module testbench
    import scg_pkg::*;
;
    logic clock = 0, nrst = 0, hsel = 0, hwrite = 0, go = 0;
    logic sleep_active = 0, deep_sleep_active = 0;
    logic [31:0] haddr = '0, hwdata = '0, run_w = 32'h0000_0040;
    logic [31:0] deep_w = '0, rd;
    logic [1:0] htrans = '0;
    logic [3:0] pick = '0;
    wire logic [31:0] hrdata;
    wire logic hreadyout, hresp, irq;
    wire logic [1:0] rate;
    wire logic [3:0] en, ua, flt, served, refused;
    int mismatches = 0, check_count = 0;
    logic [31:0] vals [6] = '{32'h0010_0000, 32'h0001_0000, 32'h0000_0100,
        32'h0000_0200, 32'h0000_0008, 32'h0000_0000};
    always #25 clock = ~clock;
    scg_sleep_gating uut (.clock(clock), .nrst(nrst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .sleep_active(sleep_active),
        .deep_sleep_active(deep_sleep_active),
        .run_unit_clock_gating0(run_w),
        .deep_sleep_unit_clock_gating0(deep_w), .unit_access(ua),
        .unit_clock_enable(en), .converter_sample_rate(rate),
        .unit_fault(flt), .irq(irq));
    scg_unit_model units (.clock(clock), .nrst(nrst), .go(go), .pick(pick),
        .unit_clock_enable(en), .unit_fault(flt), .unit_access(ua),
        .served(served), .refused(refused));
    // ====
    // Reporting and bus tasks
    task automatic conclude();
        if (mismatches == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic cmp32(string what, logic [31:0] exp, logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cmp4(string what, logic [3:0] exp, logic [3:0] got);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1) begin
            cmp4("hreadyout", 4'h1, {3'h0, hreadyout});
            conclude();
        end
    endtask
    task automatic bus(logic w, logic [11:0] a, logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {20'h0, a};
        hwrite <= w;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
        rd = hrdata;
    endtask
    task automatic chk_reg(logic [11:0] a, logic [31:0] exp, string what);
        bus(1'b0, a, 32'h0);
        cmp32(what, exp, rd);
    endtask
    task automatic settle(logic [3:0] exp);
        repeat (2) @(posedge clock);
        cmp4("enables", exp, en);
    endtask
    // ====
    // Main sequence
    initial begin
        repeat (12) @(posedge clock);
        nrst <= 1'b1;
        @(posedge clock);
        chk_reg(SLEEP_GATING_OFFSET, 32'h0000_0040, "gating");
        cmp4("enables", 4'b0100, en);
        cmp4("rate", 4'h0, {2'h0, rate});
        // Reserved bits written as ones; rate codes kept legal
        foreach (vals[i]) begin
            bus(1'b1, SLEEP_GATING_OFFSET, vals[i] | 32'hffee_fcb7);
            chk_reg(SLEEP_GATING_OFFSET, vals[i], "gating");
        end
        cmp4("enables", 4'b0100, en);
        bus(1'b1, GATING_MODE_OFFSET, 32'h1);
        bus(1'b1, SLEEP_GATING_OFFSET, 32'h0011_0208);
        sleep_active <= 1'b1;
        settle(4'b1011);
        cmp4("rate", 4'h2, {2'h0, rate});
        chk_reg(GATING_STATUS_OFFSET, 32'h0001_020b, "status");
        chk_reg(GATING_MODE_OFFSET, 32'h1, "mode");
        go <= 1'b1;
        pick <= 4'hf;
        @(posedge clock);
        go <= 1'b0;
        repeat (2) @(posedge clock);
        cmp4("served", 4'b1011, served);
        cmp4("refused", 4'b0100, refused);
        deep_w <= 32'h0000_0008;
        sleep_active <= 1'b0;
        deep_sleep_active <= 1'b1;
        settle(4'b1000);
        chk_reg(GATING_STATUS_OFFSET, 32'h0002_0008, "status");
        deep_sleep_active <= 1'b0;
        chk_reg(EVENT_STATUS_OFFSET, 32'h3, "events");
        cmp4("irq", 4'h0, {3'h0, irq});
        bus(1'b1, EVENT_ENABLE_OFFSET, 32'h1);
        @(posedge clock);
        cmp4("irq", 4'h1, {3'h0, irq});
        chk_reg(EVENT_ENABLE_OFFSET, 32'h1, "enable");
        bus(1'b1, EVENT_CLEAR_OFFSET, 32'h1);
        @(posedge clock);
        cmp4("irq", 4'h0, {3'h0, irq});
        chk_reg(EVENT_STATUS_OFFSET, 32'h2, "events");
        bus(1'b1, GATING_MODE_OFFSET, 32'h0);
        sleep_active <= 1'b1;
        settle(4'b0100);
        chk_reg(12'h200, 32'h0, "unmapped");
        // Mid-run reset brings back the documented reset word
        nrst <= 1'b0;
        repeat (2) @(posedge clock);
        nrst <= 1'b1;
        @(posedge clock);
        chk_reg(SLEEP_GATING_OFFSET, 32'h0000_0040, "gating");
        cmp4("enables", 4'b0100, en);
        chk_reg(EVENT_STATUS_OFFSET, 32'h0, "events");
        conclude();
    end
endmodule
